// file: src/ast_pkg.sv
// Package for the asynchronous serial transmitter block: register map,
// field positions, reset values, frame lengths and the state record.
// Assumes a 32-bit APB master and a single 50 MHz clock.
package ast_pkg;

	// ****************************************************************
	// Register offsets (byte addresses, one word each)
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL_ONE   = 8'h00; // serial_ctrl_one
	localparam logic [7:0] OFS_CTRL_TWO   = 8'h04; // serial_ctrl_two
	localparam logic [7:0] OFS_CTRL_THREE = 8'h08; // serial_ctrl_three
	localparam logic [7:0] OFS_STATUS_ONE = 8'h0C; // serial_status_one
	localparam logic [7:0] OFS_STATUS_TWO = 8'h10; // serial_status_two
	localparam logic [7:0] OFS_DATA       = 8'h14; // serial_data_reg
	localparam logic [7:0] OFS_BAUD       = 8'h18; // baud rate select

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int B_MODULE_ON  = 0; // ctrl one
	localparam int B_NINE_BIT   = 1;
	localparam int B_POL_FLIP   = 2;
	localparam int B_XMIT_ON    = 0; // ctrl two
	localparam int B_RCV_ON     = 1;
	localparam int B_SEND_BREAK = 2;
	localparam int B_TE_IRQ_EN  = 3;
	localparam int B_TC_IRQ_EN  = 4;
	localparam int B_TX_NINTH   = 0; // ctrl three
	localparam int B_RX_NINTH   = 1;
	localparam int B_TBE        = 0; // status one
	localparam int B_TX_DONE    = 1;
	localparam int B_RX_FULL    = 2;
	localparam int B_FRAMING    = 3;
	localparam int B_BRK_SEEN   = 0; // status two

	// ****************************************************************
	// Counts and reset values
	// ****************************************************************
	localparam logic [3:0]  FRAME_LEN_8   = 4'hA; // start + 8 + stop
	localparam logic [3:0]  FRAME_LEN_9   = 4'hB; // start + 9 + stop
	localparam logic [3:0]  SUB_LAST      = 4'hF; // 16 ticks per bit
	localparam logic [3:0]  VOTE_FIRST    = 4'h7; // mid-bit samples
	localparam logic [3:0]  VOTE_LAST     = 4'h9;
	localparam logic [15:0] PRESCALE_RST  = 16'h0004; // clocks per tick
	localparam logic [4:0]  BAUD_SEL_RST  = 5'h00;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		TX_OFF, TX_IDLE_CH, TX_DATA_CH, TX_BREAK_CH, TX_TAIL
	} ast_tx_state_t;

	typedef enum logic {RX_HUNT, RX_BITS} ast_rx_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} ast_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} ast_apb_rsp_t;

	typedef struct packed {
		logic          module_on, nine_bit, pol_flip;
		logic          xmit_on, rcv_on, send_break, te_irq_en, tc_irq_en;
		logic          tx_ninth;
		logic [4:0]    baud_sel;
		logic [15:0]   pre_cnt;
		logic [7:0]    tx_buf;
		logic          tbe, tbe_armed, idle_pend, xmit_q;
		ast_tx_state_t tx_st;
		logic [10:0]   tx_sh;
		logic [3:0]    tx_cnt, tx_sub;
		logic          pin_out, pin_en;
		logic          sync1, sync2;
		ast_rx_state_t rx_st;
		logic [3:0]    rx_sub, rx_cnt;
		logic [2:0]    votes;
		logic [9:0]    rx_sh;
		logic [7:0]    rx_data;
		logic          rx_ninth, rx_full, framing, brk_seen;
		logic [31:0]   prdata;
	} ast_state_t;

endpackage : ast_pkg

// file: src/ast_transmitter.sv
// Asynchronous serial transmitter with break detection on the receive
// side, registers reached over APB. Assumes serial_in_pin is asynchronous
// and that the pad logic muxes serial_out_pin with port logic by the enable.
//
// Summary of operation
// R1 - Character length 8 or 9 bits; ninth bit from tx_ninth_bit.
// R2 - serial_data_reg buffers one character ahead of the shift register.
// R3 - Software enables module, then transmitter, reads status then writes data.
// R4 - A transmission starts with an all-ones preamble before the data.
// R5 - Frame has zero start bit first and one stop bit last.
// R6 - Empty flag sets on buffer hand-over; interrupt when enabled.
// R7 - Pin rests at logic one while nothing shifts.
// R8 - Clearing serial_module_on releases the pins to port logic.
// R9 - While send_break, all-zero break characters repeat, length per mode.
// R10 - After break clears, finish it then send at least one one.
// R11 - Received all-zero data with zero stop is a break.
// R12 - Break sets framing_fault, rx_full_flag, break_seen_flag; clears data.
// R13 - Idle character is all ones, length per mode; it is the preamble.
// R14 - Transmitter disabled mid-character finishes it, then idles.
// R15 - Transmitter toggled off and on queues one idle character.
// R16 - Software must re-enable before the stop bit or buffered data is lost; here tx_buf is kept and sent once xmit_on is set again.
// R17 - Software should toggle xmit_on after empty flag, before next write.
// R18 - Polarity flip inverts every transmitted level.
// R19 - Done flag when buffer and shifter empty, no break or idle pending.
// R20 - Thirty-two baud rates from one generator shared by both directions.
// R21 - Transmitter and receiver enabled separately, run independently.
// R22 - One bit per baud period, start bit, data LSB first, stop bit.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module ast_transmitter #(
	parameter logic [15:0] PRESCALE = ast_pkg::PRESCALE_RST // clocks per tick
) (
	input  wire logic                 clock,          // 50 MHz clock
	input  wire logic                 arst_n,         // Async reset, low
	input  wire ast_pkg::ast_apb_req_t apb_req,       // APB request
	output var  ast_pkg::ast_apb_rsp_t apb_rsp,       // APB answer
	input  wire logic                 serial_in_pin,  // Receive pin
	output logic                      serial_out_pin, // Transmit pin level
	output logic                      serial_out_en,  // Transmit pin owned
	output logic                      tx_irq,         // Transmitter request
	output logic                      rx_irq          // Receiver full request
);

	// ****************************************************************
	// State and decode helpers
	// ****************************************************************
	ast_pkg::ast_state_t s;
	ast_pkg::ast_state_t n;
	logic                acc_wr;
	logic                acc_rd;
	logic                tick;
	logic                bit_tick;
	logic                ld_any;
	logic                ld_data;
	logic                rx_done;
	logic                rx_brk;
	logic                rx_stop;
	logic                maj;
	logic                tx_done;
	logic [3:0]          flen;
	logic [15:0]         reload;

	// Address match against one register offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	// Majority of three mid-bit samples
	function automatic logic vote(input logic [2:0] v);
		vote = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction : vote

	// Done when nothing is shifted, buffered or about to be generated
	// R19 - done flag condition
	assign tx_done = (s.tx_st == ast_pkg::TX_OFF) && s.tbe && !s.idle_pend
		&& !(s.send_break && s.xmit_on);

	// Interrupt requests are plain gates of flag and enable
	// R6 - empty interrupt request
	assign tx_irq = s.module_on && ((s.tbe && s.te_irq_en)
		|| (tx_done && s.tc_irq_en));
	assign rx_irq = s.module_on && s.rx_full;

	// APB answers at once; prdata was captured in the setup cycle
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.prdata  = s.prdata;
	assign apb_rsp.pslverr = apb_req.psel && apb_req.penable
		&& !(hit(apb_req.paddr, ast_pkg::OFS_CTRL_ONE)
		|| hit(apb_req.paddr, ast_pkg::OFS_CTRL_TWO)
		|| hit(apb_req.paddr, ast_pkg::OFS_CTRL_THREE)
		|| hit(apb_req.paddr, ast_pkg::OFS_STATUS_ONE)
		|| hit(apb_req.paddr, ast_pkg::OFS_STATUS_TWO)
		|| hit(apb_req.paddr, ast_pkg::OFS_DATA)
		|| hit(apb_req.paddr, ast_pkg::OFS_BAUD));

	// Pin outputs are flip-flops
	// R8 - pin release
	assign serial_out_pin = s.pin_out;
	assign serial_out_en  = s.pin_en;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		n        = s;
		acc_wr   = apb_req.psel && apb_req.penable && apb_req.pwrite;
		acc_rd   = apb_req.psel && apb_req.penable && !apb_req.pwrite;
		tick     = 1'b0;
		bit_tick = 1'b0;
		ld_any   = 1'b0;
		ld_data  = 1'b0;
		rx_done  = 1'b0;
		rx_brk   = 1'b0;
		rx_stop  = 1'b1;
		maj      = vote(s.votes);
		// R1 - frame length per mode
		flen     = s.nine_bit ? ast_pkg::FRAME_LEN_9 : ast_pkg::FRAME_LEN_8;
		// R20 - shared baud divider, 32 rates
		reload   = (({11'h000, s.baud_sel} + 16'h0001) * PRESCALE) - 16'h0001;
		// Second flop alone reads the first
		n.sync1 = serial_in_pin;
		n.sync2 = s.sync1;
		// Register writes take effect in the access cycle
		if (acc_wr) begin
			unique case (1'b1)
				hit(apb_req.paddr, ast_pkg::OFS_CTRL_ONE): begin
					n.module_on = apb_req.pwdata[ast_pkg::B_MODULE_ON];
					n.nine_bit  = apb_req.pwdata[ast_pkg::B_NINE_BIT];
					n.pol_flip  = apb_req.pwdata[ast_pkg::B_POL_FLIP];
				end
				hit(apb_req.paddr, ast_pkg::OFS_CTRL_TWO): begin
					n.xmit_on    = apb_req.pwdata[ast_pkg::B_XMIT_ON];
					n.rcv_on     = apb_req.pwdata[ast_pkg::B_RCV_ON];
					n.send_break = apb_req.pwdata[ast_pkg::B_SEND_BREAK];
					n.te_irq_en  = apb_req.pwdata[ast_pkg::B_TE_IRQ_EN];
					n.tc_irq_en  = apb_req.pwdata[ast_pkg::B_TC_IRQ_EN];
				end
				hit(apb_req.paddr, ast_pkg::OFS_CTRL_THREE): begin
					n.tx_ninth = apb_req.pwdata[ast_pkg::B_TX_NINTH];
				end
				hit(apb_req.paddr, ast_pkg::OFS_STATUS_TWO): begin
					// Write one to clear the break flag
					if (apb_req.pwdata[ast_pkg::B_BRK_SEEN])
						n.brk_seen = 1'b0;
				end
				hit(apb_req.paddr, ast_pkg::OFS_DATA): begin
					// R2 - holding buffer write
					n.tx_buf = apb_req.pwdata[7:0];
					// R3 - read-then-write clear
					if (s.tbe_armed)
						n.tbe = 1'b0;
					n.tbe_armed = 1'b0;
				end
				hit(apb_req.paddr, ast_pkg::OFS_BAUD): begin
					n.baud_sel = apb_req.pwdata[4:0];
				end
				default: begin
				end
			endcase
		end
		// Read side effects: status read arms, data read clears receive
		if (acc_rd && hit(apb_req.paddr, ast_pkg::OFS_STATUS_ONE) && s.tbe)
			n.tbe_armed = 1'b1;
		if (acc_rd && hit(apb_req.paddr, ast_pkg::OFS_DATA)) begin
			n.rx_full = 1'b0;
			n.framing = 1'b0;
		end
		// Read data is captured in the setup cycle, ready for access
		if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
			n.prdata = 32'h0000_0000;
			unique case (1'b1)
				hit(apb_req.paddr, ast_pkg::OFS_CTRL_ONE): begin
					n.prdata[ast_pkg::B_MODULE_ON] = s.module_on;
					n.prdata[ast_pkg::B_NINE_BIT]  = s.nine_bit;
					n.prdata[ast_pkg::B_POL_FLIP]  = s.pol_flip;
				end
				hit(apb_req.paddr, ast_pkg::OFS_CTRL_TWO): begin
					n.prdata[ast_pkg::B_XMIT_ON]    = s.xmit_on;
					n.prdata[ast_pkg::B_RCV_ON]     = s.rcv_on;
					n.prdata[ast_pkg::B_SEND_BREAK] = s.send_break;
					n.prdata[ast_pkg::B_TE_IRQ_EN]  = s.te_irq_en;
					n.prdata[ast_pkg::B_TC_IRQ_EN]  = s.tc_irq_en;
				end
				hit(apb_req.paddr, ast_pkg::OFS_CTRL_THREE): begin
					n.prdata[ast_pkg::B_TX_NINTH] = s.tx_ninth;
					n.prdata[ast_pkg::B_RX_NINTH] = s.rx_ninth;
				end
				hit(apb_req.paddr, ast_pkg::OFS_STATUS_ONE): begin
					n.prdata[ast_pkg::B_TBE]     = s.tbe;
					n.prdata[ast_pkg::B_TX_DONE] = tx_done;
					n.prdata[ast_pkg::B_RX_FULL] = s.rx_full;
					n.prdata[ast_pkg::B_FRAMING] = s.framing;
				end
				hit(apb_req.paddr, ast_pkg::OFS_STATUS_TWO):
					n.prdata[ast_pkg::B_BRK_SEEN] = s.brk_seen;
				hit(apb_req.paddr, ast_pkg::OFS_DATA):
					n.prdata[7:0] = s.rx_data;
				hit(apb_req.paddr, ast_pkg::OFS_BAUD):
					n.prdata[4:0] = s.baud_sel;
				default: begin
				end
			endcase
		end
		// 16x tick prescaler; the bit clock is every sixteenth tick
		if (!s.module_on) begin
			n.pre_cnt = 16'h0000;
			n.tx_sub  = 4'h0;
		end else if (s.pre_cnt == 16'h0000) begin
			tick      = 1'b1;
			n.pre_cnt = reload;
			n.tx_sub  = s.tx_sub + 4'h1;
		end else begin
			n.pre_cnt = s.pre_cnt - 16'h0001;
		end
		bit_tick = tick && (s.tx_sub == ast_pkg::SUB_LAST);

		// Transmit sequencer; loads only at a bit boundary
		n.xmit_q = s.xmit_on && s.module_on;
		if (!s.module_on) begin
			n.tx_st     = ast_pkg::TX_OFF;
			n.idle_pend = 1'b0;
			n.tbe       = 1'b1;
			n.tbe_armed = 1'b0;
		end else if (bit_tick) begin
			if (s.tx_st != ast_pkg::TX_OFF && s.tx_cnt > 4'h1) begin
				// R22 - one bit per period
				n.tx_sh  = {1'b1, s.tx_sh[10:1]};
				n.tx_cnt = s.tx_cnt - 4'h1;
			end else begin
				ld_any = 1'b1;
				if (s.tx_st == ast_pkg::TX_BREAK_CH && !s.send_break) begin
					// R10 - trailing one after break
					n.tx_st  = ast_pkg::TX_TAIL;
					n.tx_sh  = 11'h7FF;
					n.tx_cnt = 4'h1;
				end else if (s.xmit_on && s.send_break) begin
					// R9 - repeat break characters
					n.tx_st  = ast_pkg::TX_BREAK_CH;
					n.tx_sh  = 11'h000;
					n.tx_cnt = flen;
				end else if (s.xmit_on && s.idle_pend) begin
					// R13 - idle preamble character
					n.tx_st     = ast_pkg::TX_IDLE_CH;
					n.tx_sh     = 11'h7FF;
					n.tx_cnt    = flen;
					n.idle_pend = 1'b0;
				end else if (s.xmit_on && !s.tbe) begin
					// R5 - start low, stop high
					ld_data  = 1'b1;
					n.tx_st  = ast_pkg::TX_DATA_CH;
					n.tx_sh  = {2'b11, s.tx_buf, 1'b0};
					// R1 - ninth bit from control
					if (s.nine_bit)
						n.tx_sh[9] = s.tx_ninth;
					n.tx_cnt = flen;
				end else begin
					// R14 - idle once disabled
					n.tx_st = ast_pkg::TX_OFF;
				end
			end
		end
		// R6 - empty flag on hand-over
		if (ld_data)
			n.tbe = 1'b1;
		// R4 - preamble on enable
		// R15 - toggle queues idle
		if (s.xmit_on && s.module_on && !s.xmit_q)
			n.idle_pend = 1'b1;

		// R7 - idle level one
		// R18 - polarity flip
		n.pin_out = n.pol_flip ^ ((n.tx_st == ast_pkg::TX_OFF) ? 1'b1
			: n.tx_sh[0]);
		// R8 - pins follow module enable
		n.pin_en  = n.module_on;

		// Receiver, enabled apart from the transmitter
		// R21 - independent receiver
		if (!(s.module_on && s.rcv_on)) begin
			n.rx_st = ast_pkg::RX_HUNT;
		end else if (tick) begin
			unique case (s.rx_st)
				ast_pkg::RX_HUNT: begin
					if (!s.sync2) begin
						n.rx_st  = ast_pkg::RX_BITS;
						n.rx_sub = 4'h0;
						n.rx_cnt = 4'h0;
					end
				end
				ast_pkg::RX_BITS: begin
					n.rx_sub = s.rx_sub + 4'h1;
					if (s.rx_sub >= ast_pkg::VOTE_FIRST
							&& s.rx_sub <= ast_pkg::VOTE_LAST)
						n.votes = {s.votes[1:0], s.sync2};
					if (s.rx_sub == ast_pkg::SUB_LAST) begin
						if (s.rx_cnt == 4'h0 && maj) begin
							n.rx_st = ast_pkg::RX_HUNT;
						end else begin
							if (s.rx_cnt != 4'h0)
								n.rx_sh[s.rx_cnt - 4'h1] = maj;
							n.rx_cnt = s.rx_cnt + 4'h1;
							if (s.rx_cnt == flen - 4'h1) begin
								rx_done = 1'b1;
								n.rx_st = ast_pkg::RX_HUNT;
							end
						end
					end
				end
			endcase
		end

		// R11 - break recognition
		rx_stop = s.nine_bit ? n.rx_sh[9] : n.rx_sh[8];
		rx_brk  = rx_done && !rx_stop && (n.rx_sh[7:0] == 8'h00)
			&& !(s.nine_bit && n.rx_sh[8]);
		// R12 - break effects on flags
		if (rx_done) begin
			n.rx_full  = 1'b1;
			n.framing  = !rx_stop;
			n.rx_data  = rx_brk ? 8'h00 : n.rx_sh[7:0];
			n.rx_ninth = rx_brk ? 1'b0
				: (s.nine_bit ? n.rx_sh[8] : n.rx_sh[7]);
			if (rx_brk)
				n.brk_seen = 1'b1;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s          <= '0;
			s.baud_sel <= ast_pkg::BAUD_SEL_RST;
			s.tbe      <= 1'b1;
			s.tx_st    <= ast_pkg::TX_OFF;
			s.rx_st    <= ast_pkg::RX_HUNT;
			s.pin_out  <= 1'b1;
			s.sync1    <= 1'b1;
			s.sync2    <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_break_end;
		s.tx_st == ast_pkg::TX_BREAK_CH && s.tx_cnt == 4'h1 && bit_tick
			&& !s.send_break && s.module_on;
	endsequence

	a_empty_on_load: assert property ( // R6
		ld_data |=> s.tbe && s.tx_st == ast_pkg::TX_DATA_CH)
		else $error("empty flag not set on hand-over");
	a_start_bit_low: assert property ( // R5
		ld_data |=> (serial_out_pin ^ s.pol_flip) == 1'b0)
		else $error("start bit not low");
	a_stop_bit_high: assert property ( // R5
		s.tx_st == ast_pkg::TX_DATA_CH && s.tx_cnt == 4'h1
			|-> (serial_out_pin ^ s.pol_flip))
		else $error("stop bit not high");
	a_idle_level_one: assert property ( // R7
		s.tx_st == ast_pkg::TX_OFF |-> serial_out_pin == !s.pol_flip)
		else $error("idle level wrong");
	a_break_all_zero: assert property ( // R9
		s.tx_st == ast_pkg::TX_BREAK_CH |-> serial_out_pin == s.pol_flip)
		else $error("break bit not zero");
	a_break_tail_one: assert property ( // R10
		s_break_end |=> s.tx_st == ast_pkg::TX_TAIL && serial_out_pin
			== !s.pol_flip)
		else $error("no one after break");
	a_pin_release: assert property ( // R8
		acc_wr && hit(apb_req.paddr, ast_pkg::OFS_CTRL_ONE)
			&& !apb_req.pwdata[ast_pkg::B_MODULE_ON] |=> !serial_out_en)
		else $error("pin not released");
	a_idle_queued: assert property ( // R15
		ld_any && s.idle_pend && s.xmit_on && !s.send_break
			&& s.tx_st != ast_pkg::TX_BREAK_CH
			|=> s.tx_st == ast_pkg::TX_IDLE_CH && s.tx_cnt == flen)
		else $error("queued idle not sent");
	a_break_flags: assert property ( // R12
		rx_brk |=> s.brk_seen && s.framing && s.rx_full
			&& s.rx_data == 8'h00 && !s.rx_ninth)
		else $error("break flags wrong");
	a_done_irq: assert property ( // R19
		s.module_on && s.tc_irq_en && s.tx_st == ast_pkg::TX_OFF && s.tbe
			&& !s.idle_pend && !s.send_break |-> tx_irq)
		else $error("done request missing");

endmodule : ast_transmitter
`default_nettype wire

// file: verif/ast_far_end.sv
// Far-end serial device: decodes frames seen on the transmit wire and
// sends characters, breaks included, into the receive pin.
// Assumes the bench hands it the wire level with inversion undone.
`timescale 1ns/1ns
`default_nettype none

module ast_far_end (
	input  wire logic       clock,   // Bench clock
	input  wire logic       line,    // Wire level seen
	input  wire logic       nine,    // Nine data bits
	input  wire logic [7:0] bit_len, // Clocks per bit
	output logic            to_dut,  // Our sending line
	output logic            busy,    // Inside a frame
	output logic [15:0]     frames,  // Frames decoded
	output logic [8:0]      word,    // Last data bits
	output logic            stop     // Last stop level
);
	logic [8:0] sh;

	initial begin
		to_dut = 1'b1;
		busy = 1'b0;
		frames = 16'h0000;
		word = 9'h000;
		stop = 1'b1;
	end

	// ****************************************************************
	// Receive side
	// ****************************************************************
	// bit order
	// A start must still be low at mid-bit, so short glitches are dropped
	always begin
		@(negedge line);
		busy = 1'b1;
		repeat (bit_len / 2) @(posedge clock);
		if (line === 1'b0) begin
			sh = 9'h000;
			for (int i = 0; i < (nine ? 9 : 8); i++) begin
				repeat (bit_len) @(posedge clock);
				sh[i] = line;
			end
			repeat (bit_len) @(posedge clock);
			stop = line;
			word = sh;
			frames = frames + 16'h0001;
		end
		busy = 1'b0;
	end

	// ****************************************************************
	// Send side
	// ****************************************************************
	// character or break frame
	// A low stop level with zero data makes a break; line returns high
	task automatic send_char(input logic [8:0] d, input logic stop_lvl);
		logic [10:0] fr;
		fr = {stop_lvl, d, 1'b0};
		for (int i = 0; i < (nine ? 11 : 10); i++) begin
			@(posedge clock);
			to_dut <= (i == (nine ? 10 : 9)) ? stop_lvl : fr[i];
			repeat (bit_len - 1) @(posedge clock);
		end
		@(posedge clock);
		to_dut <= 1'b1;
	endtask : send_char
endmodule : ast_far_end
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the serial transmitter: APB master tasks,
// random and corner-case characters, far-end model on both pins.
// Assumes PRESCALE of one, so a bit lasts sixteen clocks at baud 0.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	ast_pkg::ast_apb_req_t req;
	ast_pkg::ast_apb_rsp_t rsp;
	logic        clock, arst_n, pin, pin_en, tx_irq, rx_irq, rx_line;
	logic        flip, nine, line, fbusy, fstop, err;
	logic [7:0]  bit_len;
	logic [8:0]  fword;
	logic [15:0] nframes;
	logic [31:0] q, d;
	int          err_total, samples_checked, t;
	integer      seed;

	// Released pad floats to the pull-up; inversion undone for the model
	assign line = (pin_en ? pin : 1'b1) ^ flip;

	ast_transmitter #(.PRESCALE(16'h0001)) u_ast_transmitter (
		.clock(clock), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
		.serial_in_pin(rx_line), .serial_out_pin(pin),
		.serial_out_en(pin_en), .tx_irq(tx_irq), .rx_irq(rx_irq));

	ast_far_end u_ast_far_end (
		.clock(clock), .line(line), .nine(nine), .bit_len(bit_len),
		.to_dut(rx_line), .busy(fbusy), .frames(nframes), .word(fword),
		.stop(fstop));

	always #10 clock = ~clock;

	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// A wait that used up its bound counts once and closes the run
	task automatic timed_out(input int c, input int lim);
		if (c >= lim) begin
			err_total++;
			test_done();
		end
	endtask : timed_out

	// Far-end word: the ninth bit counts only in nine-bit mode
	function automatic logic [8:0] exp_word(input logic b8,
		input logic [7:0] v);
		exp_word = {nine & b8, v};
	endfunction : exp_word

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	// ****************************************************************
	// Bus and link tasks
	// ****************************************************************
	// Idle cycle first, so a release is never reassigned in one step
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		int n;
		@(posedge clock);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: v};
		@(posedge clock);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (rsp.pready !== 1'b1 && n < 16);
		if (rsp.pready !== 1'b1) begin
			err_total++;
			test_done();
		end
		q = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask : wr

	// Cycles until the start bit is seen come back in c
	task automatic wait_frame(output int c);
		logic [15:0] n0;
		int n;
		n0 = nframes;
		c = -1;
		for (n = 0; n < 4000 && nframes == n0; n++) begin
			@(posedge clock);
			if (fbusy === 1'b1 && c < 0) c = n;
		end
		if (nframes == n0) begin
			err_total++;
			test_done();
		end
	endtask : wait_frame

	task automatic xfer(input logic [7:0] v);
		rd(ast_pkg::OFS_STATUS_ONE);
		wr(ast_pkg::OFS_DATA, {24'h0, v});
		wait_frame(t);
		repeat (12) @(posedge clock);
	endtask : xfer

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		req = '0;
		flip = 1'b0;
		nine = 1'b0;
		bit_len = 8'h10;
		seed = 34;
		err_total = 0;
		samples_checked = 0;
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		// Reset values, then an unmapped word
		for (int a = 0; a < 32; a += 4) begin
			rd(a[7:0]);
			if (a == 12) chk("status reset", q[0], 1);
			else if (a == 28) chk("unmapped", err, 1);
			else chk("reg reset", q, 0);
		end
		$display("test registers done");
		wr(ast_pkg::OFS_CTRL_ONE, 32'h1);
		repeat (2) @(posedge clock);
		chk("pin owned", pin_en, 1);
		chk("idle level", pin, 1);
		wr(ast_pkg::OFS_CTRL_TWO, 32'h0B);
		rd(ast_pkg::OFS_STATUS_ONE);
		wr(ast_pkg::OFS_DATA, 32'h3C);
		rd(ast_pkg::OFS_STATUS_ONE);
		chk("buffer held", q[0], 0);
		wait_frame(t);
		chk("preamble", (t >= 140 && t <= 200), 1);
		chk("first data", fword, 9'h03C);
		chk("first stop", fstop, 1);
		chk("empty irq", tx_irq, 1);
		repeat (16) @(posedge clock);
		rd(ast_pkg::OFS_STATUS_ONE);
		chk("done flags", q[1:0], 2'b11);
		$display("test preamble done");
		// Random characters, the last one at a slower baud select
		for (int i = 0; i < 6; i++) begin
			d = $random(seed);
			if (i == 5) begin
				wr(ast_pkg::OFS_BAUD, 32'h1);
				bit_len = 8'h20;
			end
			xfer(d[7:0]);
			chk("random data", fword, exp_word(1'b1, d[7:0]));
			chk("random stop", fstop, 1);
		end
		wr(ast_pkg::OFS_BAUD, 32'h0);
		bit_len = 8'h10;
		$display("test random done");
		nine = 1'b1;
		wr(ast_pkg::OFS_CTRL_ONE, 32'h3);
		for (int b = 0; b < 2; b++) begin
			wr(ast_pkg::OFS_CTRL_THREE, b);
			xfer(8'h5A);
			chk("ninth bit", fword, exp_word(b[0], 8'h5A));
		end
		nine = 1'b0;
		wr(ast_pkg::OFS_CTRL_ONE, 32'h5);
		flip = 1'b1;
		repeat (2) @(posedge clock);
		chk("inverted idle", pin, 0);
		xfer(8'hC3);
		chk("inverted data", fword, 9'h0C3);
		wr(ast_pkg::OFS_CTRL_ONE, 32'h1);
		flip = 1'b0;
		repeat (16) @(posedge clock);
		$display("test modes done");
		// Transmitter switched off while a character is on the wire
		rd(ast_pkg::OFS_STATUS_ONE);
		wr(ast_pkg::OFS_DATA, 32'h96);
		for (t = 0; t < 400 && fbusy !== 1'b1; t++) @(posedge clock);
		timed_out(t, 400);
		wr(ast_pkg::OFS_CTRL_TWO, 32'h0A);
		wait_frame(t);
		chk("finish char", fword, 9'h096);
		repeat (40) @(posedge clock);
		chk("rest high", line, 1);
		// Break characters, then release
		wr(ast_pkg::OFS_CTRL_TWO, 32'h17);
		wait_frame(t);
		chk("break data", {fstop, fword}, 10'h000);
		repeat (20) @(posedge clock);
		chk("break again", line, 0);
		chk("no done irq", tx_irq, 0);
		wr(ast_pkg::OFS_CTRL_TWO, 32'h13);
		for (t = 0; t < 400 && line !== 1'b1; t++) @(posedge clock);
		timed_out(t, 400);
		repeat (8) @(posedge clock);
		chk("one after break", line, 1);
		// Tail bit and the preamble queued by the enable both go out first
		repeat (200) @(posedge clock);
		rd(ast_pkg::OFS_STATUS_ONE);
		chk("done after break", q[1:0], 2'b11);
		chk("done irq", tx_irq, 1);
		$display("test break done");
		// toggle after the empty flag, before the next write
		rd(ast_pkg::OFS_STATUS_ONE);
		wr(ast_pkg::OFS_DATA, 32'h81);
		for (t = 0; t < 40; t++) begin
			rd(ast_pkg::OFS_STATUS_ONE);
			if (q[0] === 1'b1) break;
		end
		timed_out(t, 40);
		wr(ast_pkg::OFS_CTRL_TWO, 32'h12);
		wr(ast_pkg::OFS_CTRL_TWO, 32'h13);
		rd(ast_pkg::OFS_STATUS_ONE);
		wr(ast_pkg::OFS_DATA, 32'h42);
		wait_frame(t);
		chk("before idle", fword, 9'h081);
		wait_frame(t);
		chk("queued idle", (t >= 150 && t <= 200), 1);
		chk("after idle", fword, 9'h042);
		$display("test toggle done");
		// Receive a nine-bit character, then a break
		wr(ast_pkg::OFS_CTRL_ONE, 32'h3);
		nine = 1'b1;
		u_ast_far_end.send_char(9'h1A5, 1'b1);
		repeat (4) @(posedge clock);
		chk("rx irq", rx_irq, 1);
		rd(ast_pkg::OFS_STATUS_ONE);
		chk("rx flags", q[3:2], 2'b01);
		rd(ast_pkg::OFS_CTRL_THREE);
		chk("rx ninth", q[1], 1);
		rd(ast_pkg::OFS_DATA);
		chk("rx data", q, 32'hA5);
		u_ast_far_end.send_char(9'h000, 1'b0);
		repeat (4) @(posedge clock);
		rd(ast_pkg::OFS_STATUS_ONE);
		chk("break flags", q[3:2], 2'b11);
		rd(ast_pkg::OFS_STATUS_TWO);
		chk("break seen", q[0], 1);
		rd(ast_pkg::OFS_CTRL_THREE);
		chk("ninth cleared", q[1], 0);
		rd(ast_pkg::OFS_DATA);
		chk("data cleared", q, 0);
		$display("test receive done");
		wr(ast_pkg::OFS_CTRL_ONE, 32'h0);
		repeat (2) @(posedge clock);
		chk("pin released", pin_en, 0);
		$display("test release done");
		test_done();
	end
endmodule : tb_top
`default_nettype wire
